// file: psdma_channel.sv
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
// What this block does
// - Byte move takes two bus cycles
// - Block done with enable raises CPU irq
// - Control 0x87: inc src, byte, source 7
// - Control 0x00: static both, byte, source 0
// - Block length counts bytes per block
// - System reset value: no loop, CPU first
// - System 0x10 enables looping on channel
// - Control one 0x03: 25%, enable, irq
// - Control one 0xc2: 100%, enable, no irq
// - Control two zero forces no request
// - Three-bit field picks serviced request
// - Pending request of selected source gets one transfer
// - Byte mode moves one byte per request
// - Word four cycles, plus two setup cycles
// - Block done sets flag, clears enable unless looping
// - System 0x80 gives DMA priority
// - Control two bit forces matching source
module psdma_channel (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [7:0]            periph_req,
  input  wire logic                  cpu_irq_pending,
  input  wire logic                  cpu_wait,
  output psdma_pkg::psdma_mem_t      mem_out,
  input  wire logic [7:0]            mem_rdata,
  output logic                       dma_irq
);
  logic                   wait_reg, wait_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [7:0]             ctl_reg, ctl_next;
  logic [7:0]             blen_reg, blen_next;
  logic [7:0]             sys_reg, sys_next;
  logic [7:0]             dc1_reg, dc1_next;
  logic [7:0]             dc2_reg, dc2_next;
  logic [15:0]            src_reg, src_next;
  logic [15:0]            dst_reg, dst_next;
  logic [15:0]            cur_src_reg, cur_src_next;
  logic [15:0]            cur_dst_reg, cur_dst_next;
  logic [8:0]             cnt_reg, cnt_next;
  logic                   phase_reg, phase_next;
  logic                   active_reg, active_next;
  logic                   done_reg, done_next;
  logic [7:0]             pend_reg, pend_next;
  logic [7:0]             rbuf_reg, rbuf_next;
  logic [1:0]             setup_reg, setup_next;
  logic [3:0]             bw_reg, bw_next;
  logic [3:0]             bw_limit;
  logic                   irq_next;
  logic                   wr_commit;
  logic                   go;
  logic [2:0]             sel;
  logic [8:0]             step;
  psdma_pkg::psdma_state_t state_reg;
  psdma_pkg::psdma_state_t state_next;
  psdma_pkg::psdma_mem_t   mem_next;

  assign wr_commit = avs_write && !wait_reg;
  assign sel       = ctl_reg[psdma_pkg::CTL_SEL_LSB +: 3];
  assign step      = ctl_reg[psdma_pkg::CTL_WORD] ? 9'h002 : 9'h001;

  // Bus slave: one wait cycle, then the answer stands for one cycle
  always_comb
  begin
    wait_next  = !((avs_read || avs_write) && wait_reg);
    rdata_next = rdata_reg;
    if (avs_read && wait_reg)
    begin
      unique case (avs_address)
        psdma_pkg::OFS_CTRL: rdata_next = {24'h000000, ctl_reg};
        psdma_pkg::OFS_BLEN: rdata_next = {24'h000000, blen_reg};
        psdma_pkg::OFS_SYS:  rdata_next = {24'h000000, sys_reg};
        psdma_pkg::OFS_DC1:  rdata_next = {24'h000000, dc1_reg};
        psdma_pkg::OFS_DC2:  rdata_next = {24'h000000, dc2_reg};
        psdma_pkg::OFS_SRC:  rdata_next = {16'h0000, src_reg};
        psdma_pkg::OFS_DST:  rdata_next = {16'h0000, dst_reg};
        psdma_pkg::OFS_STAT: rdata_next = {8'h00, pend_reg, 3'h0, active_reg,
                                           state_reg != psdma_pkg::ST_IDLE, 2'h0, cnt_reg};
        default:             rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  always_comb
  begin
    unique case (dc1_reg[psdma_pkg::DC1_BW_LSB +: 2])
      2'h0: bw_limit = psdma_pkg::BW_SLOTS_25;
      2'h1: bw_limit = psdma_pkg::BW_SLOTS_50;
      2'h2: bw_limit = psdma_pkg::BW_SLOTS_67;
      2'h3: bw_limit = psdma_pkg::BW_SLOTS_100;
    endcase
  end

  // Waiting or CPU interrupt blocks new services only
  assign go = (pend_reg[sel] || dc2_reg[sel])
              && !(cpu_wait && !sys_reg[psdma_pkg::SYS_WAIT_EN])
              && !(cpu_irq_pending && !sys_reg[psdma_pkg::SYS_PRIO]);

  always_comb
  begin
    ctl_next     = ctl_reg;
    blen_next    = blen_reg;
    sys_next     = sys_reg;
    dc1_next     = dc1_reg;
    dc2_next     = dc2_reg;
    src_next     = src_reg;
    dst_next     = dst_reg;
    cur_src_next = cur_src_reg;
    cur_dst_next = cur_dst_reg;
    cnt_next     = cnt_reg;
    phase_next   = phase_reg;
    active_next  = active_reg;
    rbuf_next    = rbuf_reg;
    setup_next   = setup_reg;
    state_next   = state_reg;
    done_next    = 1'b0;
    bw_next      = (bw_reg == psdma_pkg::BW_WINDOW - 4'h1) ? 4'h0 : bw_reg + 4'h1;
    // Set wins: a request in the clearing cycle stays pending
    pend_next    = pend_reg | periph_req;
    if (wr_commit)
    begin
      unique case (avs_address)
        psdma_pkg::OFS_CTRL: ctl_next  = avs_writedata[7:0];
        psdma_pkg::OFS_BLEN: blen_next = avs_writedata[7:0];
        psdma_pkg::OFS_SYS:  sys_next  = avs_writedata[7:0];
        psdma_pkg::OFS_DC1:  dc1_next  = avs_writedata[7:0];
        psdma_pkg::OFS_DC2:  dc2_next  = avs_writedata[7:0];
        psdma_pkg::OFS_SRC:  src_next  = avs_writedata[15:0];
        psdma_pkg::OFS_DST:  dst_next  = avs_writedata[15:0];
        default:
        begin
        end
      endcase
    end
    unique case (state_reg)
      psdma_pkg::ST_IDLE:
      begin
        if (dc1_reg[psdma_pkg::DC1_TEC] && !active_reg)
        begin
          cur_src_next = src_reg;
          cur_dst_next = dst_reg;
          cnt_next     = (blen_reg == 8'h00) ? psdma_pkg::FULL_BLOCK : {1'b0, blen_reg};
          active_next  = 1'b1;
        end
        else if (dc1_reg[psdma_pkg::DC1_TEC] && go)
        begin
          pend_next[sel] = periph_req[sel];
          setup_next     = 2'h0;
          state_next     = psdma_pkg::ST_SETUP;
        end
        // Disabling drops the loaded block so a new enable reloads it
        else if (!dc1_reg[psdma_pkg::DC1_TEC])
          active_next = 1'b0;
      end
      psdma_pkg::ST_SETUP:
      begin
        if (setup_reg == psdma_pkg::SETUP_CYCLES - 2'h1)
          state_next = psdma_pkg::ST_READ;
        else
          setup_next = setup_reg + 2'h1;
      end
      psdma_pkg::ST_READ:
      begin
        if (mem_out.en)
        begin
          rbuf_next  = mem_rdata;
          state_next = psdma_pkg::ST_WRITE;
        end
      end
      psdma_pkg::ST_WRITE:
      begin
        if (mem_out.en && ctl_reg[psdma_pkg::CTL_WORD] && !phase_reg)
        begin
          phase_next = 1'b1;
          state_next = psdma_pkg::ST_READ;
        end
        else if (mem_out.en)
        begin
          phase_next = 1'b0;
          state_next = psdma_pkg::ST_IDLE;
          cnt_next   = (cnt_reg > step) ? cnt_reg - step : 9'h000;
          if (ctl_reg[psdma_pkg::CTL_SRC_INC])
            cur_src_next = cur_src_reg + {7'h00, step};
          if (ctl_reg[psdma_pkg::CTL_DST_INC])
            cur_dst_next = cur_dst_reg + {7'h00, step};
          if (cnt_reg <= step)
          begin
            done_next             = 1'b1;
            active_next           = 1'b0;
            sys_next[psdma_pkg::SYS_ICF] = 1'b1;
            if (!sys_reg[psdma_pkg::SYS_LOOP])
              dc1_next[psdma_pkg::DC1_TEC] = 1'b0;
          end
        end
      end
    endcase
    // Bus cycle only inside the share
    mem_next.en    = (bw_next < bw_limit)
                     && (state_next == psdma_pkg::ST_READ || state_next == psdma_pkg::ST_WRITE);
    mem_next.we    = state_next == psdma_pkg::ST_WRITE;
    mem_next.addr  = mem_next.we ? cur_dst_next + {15'h0000, phase_next}
                                 : cur_src_next + {15'h0000, phase_next};
    mem_next.wdata = rbuf_next;
    irq_next       = sys_next[psdma_pkg::SYS_ICF] && dc1_next[psdma_pkg::DC1_IE];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctl_reg     <= psdma_pkg::RST_BYTE;
      blen_reg    <= psdma_pkg::RST_BYTE;
      sys_reg     <= psdma_pkg::RST_BYTE;
      dc1_reg     <= psdma_pkg::RST_BYTE;
      dc2_reg     <= psdma_pkg::RST_BYTE;
      src_reg     <= psdma_pkg::RST_ADDR;
      dst_reg     <= psdma_pkg::RST_ADDR;
      cur_src_reg <= psdma_pkg::RST_ADDR;
      cur_dst_reg <= psdma_pkg::RST_ADDR;
      cnt_reg     <= 9'h000;
      phase_reg   <= 1'b0;
      active_reg  <= 1'b0;
      done_reg    <= 1'b0;
      pend_reg    <= 8'h00;
      rbuf_reg    <= 8'h00;
      setup_reg   <= 2'h0;
      bw_reg      <= 4'h0;
      state_reg   <= psdma_pkg::ST_IDLE;
      mem_out     <= '0;
      dma_irq     <= 1'b0;
    end
    else
    begin
      ctl_reg     <= ctl_next;
      blen_reg    <= blen_next;
      sys_reg     <= sys_next;
      dc1_reg     <= dc1_next;
      dc2_reg     <= dc2_next;
      src_reg     <= src_next;
      dst_reg     <= dst_next;
      cur_src_reg <= cur_src_next;
      cur_dst_reg <= cur_dst_next;
      cnt_reg     <= cnt_next;
      phase_reg   <= phase_next;
      active_reg  <= active_next;
      done_reg    <= done_next;
      pend_reg    <= pend_next;
      rbuf_reg    <= rbuf_next;
      setup_reg   <= setup_next;
      bw_reg      <= bw_next;
      state_reg   <= state_next;
      mem_out     <= mem_next;
      dma_irq     <= irq_next;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_byte_two_cycles: assert property (
    (state_reg == psdma_pkg::ST_READ && mem_out.en && !ctl_reg[psdma_pkg::CTL_WORD]
     && bw_limit == psdma_pkg::BW_SLOTS_100)
    |=> (state_reg == psdma_pkg::ST_WRITE && mem_out.en) ##1 state_reg == psdma_pkg::ST_IDLE)
    else $error("byte move did not finish in two bus cycles");
  a_irq_on_done: assert property (
    done_reg && dc1_reg[psdma_pkg::DC1_IE] |-> dma_irq)
    else $error("block done without interrupt");
  a_ctl_decode: assert property (
    wr_commit && avs_address == psdma_pkg::OFS_CTRL && avs_writedata[7:0] == 8'h87
    |=> sel == 3'h7 && ctl_reg[psdma_pkg::CTL_SRC_INC] && !ctl_reg[psdma_pkg::CTL_DST_INC])
    else $error("control decode wrong");
  a_len_load: assert property (
    state_reg == psdma_pkg::ST_IDLE && dc1_reg[psdma_pkg::DC1_TEC] && !active_reg
    |=> cnt_reg == (($past(blen_reg) == 8'h00) ? 9'h100 : {1'b0, $past(blen_reg)}))
    else $error("byte count not loaded from block length");
  a_setup_two: assert property (
    $rose(state_reg == psdma_pkg::ST_SETUP)
    |-> (state_reg == psdma_pkg::ST_SETUP)[*2] ##1 state_reg == psdma_pkg::ST_READ)
    else $error("setup not two cycles");
  a_done_flags: assert property (
    done_reg && !$past(wr_commit)
    |-> sys_reg[psdma_pkg::SYS_ICF] && dc1_reg[psdma_pkg::DC1_TEC] == $past(sys_reg[psdma_pkg::SYS_LOOP]))
    else $error("completion flags wrong");
  a_loop_reload: assert property (
    done_reg && dc1_reg[psdma_pkg::DC1_TEC] |=> active_reg && cnt_reg != 9'h000)
    else $error("loop did not reload");
  a_bw_slot: assert property (
    mem_out.en |-> bw_reg < bw_limit)
    else $error("bus cycle outside share");
  a_cpu_prio: assert property (
    state_reg == psdma_pkg::ST_IDLE && !sys_reg[psdma_pkg::SYS_PRIO] && cpu_irq_pending
    |=> state_reg != psdma_pkg::ST_SETUP)
    else $error("service started over CPU interrupt");

  c_word_move: cover property (ctl_reg[psdma_pkg::CTL_WORD] && phase_reg && mem_out.we);
  c_loop_done: cover property (done_reg && sys_reg[psdma_pkg::SYS_LOOP]);
  c_forced_done: cover property (done_reg && dc2_reg[sel]);
endmodule

// file: psdma_pkg.sv
package psdma_pkg;
  // Register byte offsets on the slave bus
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_BLEN = 5'h04;
  localparam logic [4:0] OFS_SYS  = 5'h08;
  localparam logic [4:0] OFS_DC1  = 5'h0c;
  localparam logic [4:0] OFS_DC2  = 5'h10;
  localparam logic [4:0] OFS_SRC  = 5'h14;
  localparam logic [4:0] OFS_DST  = 5'h18;
  localparam logic [4:0] OFS_STAT = 5'h1c;
  // Channel control fields
  localparam int CTL_SRC_INC = 7;
  localparam int CTL_DST_INC = 5;
  localparam int CTL_WORD    = 3;
  localparam int CTL_SEL_LSB = 0;
  // System control fields
  localparam int SYS_PRIO    = 7;
  localparam int SYS_LOOP    = 4;
  localparam int SYS_WAIT_EN = 3;
  localparam int SYS_ICF     = 0;
  // Control one fields
  localparam int DC1_BW_LSB  = 6;
  localparam int DC1_TEC     = 1;
  localparam int DC1_IE      = 0;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  // Timing in bus cycles
  localparam logic [1:0] SETUP_CYCLES = 2'h2;
  localparam logic [3:0] BW_WINDOW    = 4'hc;
  localparam logic [3:0] BW_SLOTS_25  = 4'h3;
  localparam logic [3:0] BW_SLOTS_50  = 4'h6;
  localparam logic [3:0] BW_SLOTS_67  = 4'h8;
  localparam logic [3:0] BW_SLOTS_100 = 4'hc;
  localparam logic [8:0] FULL_BLOCK   = 9'h100;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_READ, ST_WRITE} psdma_state_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } psdma_mem_t;
endpackage

// file: psdma_far.sv
`timescale 1ns/100ps
module psdma_far (
  input  wire logic                  core_clk,
  input  wire psdma_pkg::psdma_mem_t mem_out,
  input  wire logic [7:0]            req_cmd,
  output logic      [7:0]            periph_req = 8'h00,
  output logic      [7:0]            mem_rdata
);
  logic [7:0]  last_reg = 8'h00;
  logic [7:0]  lat_reg = 8'h00;
  logic        rd_reg = 1'b0;
  logic [15:0] wa_q[$];
  logic [7:0]  wd_q[$];
  logic [15:0] ra_q[$];
  logic [7:0]  lat_q[$];
  logic        ok_q[$];
  // Idle data bus flips away from the last byte so a stale read never matches
  always_comb
  begin
    if (mem_out.en && !mem_out.we)
      mem_rdata = mem_out.addr[7:0] ^ 8'h5a;
    else
      mem_rdata = ~last_reg;
  end
  always @(posedge core_clk)
  begin
    periph_req <= req_cmd;
    last_reg <= mem_rdata;
    rd_reg <= mem_out.en && !mem_out.we;
    lat_reg <= (periph_req != 8'h00) ? 8'h00 : lat_reg + 8'h01;
    if (mem_out.en && !mem_out.we)
    begin
      ra_q.push_back(mem_out.addr);
      lat_q.push_back(lat_reg);
    end
    if (mem_out.en && mem_out.we)
    begin
      wa_q.push_back(mem_out.addr);
      wd_q.push_back(mem_out.wdata);
      ok_q.push_back(rd_reg);
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [4:0]            avs_address = 5'h00;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [7:0]            req_cmd = 8'h00;
  logic [7:0]            periph_req;
  logic                  cpu_irq_pending = 1'b0;
  logic                  cpu_wait = 1'b0;
  psdma_pkg::psdma_mem_t mem_out;
  logic [7:0]            mem_rdata;
  logic                  dma_irq;
  logic [31:0]           rd_val;
  int                    fail_count = 0;
  int                    n_compared = 0;
  int                    i;

  always #5 core_clk = ~core_clk;

  psdma_channel psdma_channel_inst (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_req(periph_req),
    .cpu_irq_pending(cpu_irq_pending), .cpu_wait(cpu_wait), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .dma_irq(dma_irq));
  psdma_far psdma_far_inst (.core_clk(core_clk), .mem_out(mem_out), .req_cmd(req_cmd),
    .periph_req(periph_req), .mem_rdata(mem_rdata));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("Counts: %0d mismatches of %0d compared", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd_val = avs_readdata;
    if (n >= 50)
      fail_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task pulse(input int s);
    @(posedge core_clk);
    req_cmd <= 8'h01 << s;
    @(posedge core_clk);
    req_cmd <= 8'h00;
  endtask

  task wait_wr(input int k);
    int n;
    n = 0;
    while (psdma_far_inst.wa_q.size() < k && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (30) @(posedge core_clk);
    check(psdma_far_inst.wa_q.size(), k);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict;
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      bus(1'b0, 5'(i * 4), 32'h0);
      check(rd_val, 32'h0);
    end
    bus(1'b1, psdma_pkg::OFS_STAT, 32'hff);
    bus(1'b0, psdma_pkg::OFS_STAT, 32'h0);
    check(rd_val, 32'h0);
    // Serial transmit style block, one byte per request
    bus(1'b1, psdma_pkg::OFS_SRC, 32'h0001_0010);
    bus(1'b0, psdma_pkg::OFS_SRC, 32'h0);
    check(rd_val, 32'h10);
    bus(1'b1, psdma_pkg::OFS_DST, 32'h40);
    bus(1'b1, psdma_pkg::OFS_CTRL, 32'h87);
    bus(1'b1, psdma_pkg::OFS_BLEN, 32'h0d);
    bus(1'b1, psdma_pkg::OFS_DC1, 32'h03);
    for (i = 0; i < 13; i++)
    begin
      pulse(7);
      wait_wr(i + 1);
      check(dma_irq, 32'(i == 12));
      check(psdma_far_inst.wa_q[i], 32'h40);
      check(psdma_far_inst.ra_q[i], 32'h10 + i);
      check(psdma_far_inst.wd_q[i], (32'h10 + i) ^ 32'h5a);
    end
    bus(1'b0, psdma_pkg::OFS_DC1, 32'h0);
    check(rd_val, 32'h01);
    bus(1'b0, psdma_pkg::OFS_SYS, 32'h0);
    check(rd_val, 32'h01);
    bus(1'b1, psdma_pkg::OFS_SYS, 32'h0);
    repeat (2) @(posedge core_clk);
    check(dma_irq, 32'h0);
    // Looping single byte, static addresses
    bus(1'b1, psdma_pkg::OFS_SRC, 32'h20);
    bus(1'b1, psdma_pkg::OFS_DST, 32'h30);
    bus(1'b1, psdma_pkg::OFS_CTRL, 32'h00);
    bus(1'b1, psdma_pkg::OFS_BLEN, 32'h01);
    bus(1'b1, psdma_pkg::OFS_SYS, 32'h10);
    bus(1'b1, psdma_pkg::OFS_DC1, 32'hc2);
    repeat (4) @(posedge core_clk);
    cpu_wait <= 1'b1;
    pulse(0);
    repeat (30) @(posedge core_clk);
    check(psdma_far_inst.wa_q.size(), 13);
    cpu_wait <= 1'b0;
    cpu_irq_pending <= 1'b1;
    repeat (30) @(posedge core_clk);
    check(psdma_far_inst.wa_q.size(), 13);
    cpu_irq_pending <= 1'b0;
    wait_wr(14);
    for (i = 14; i < 16; i++)
    begin
      pulse(0);
      wait_wr(i + 1);
      check(psdma_far_inst.lat_q[i], 32'h3);
      check(psdma_far_inst.wa_q[i], 32'h30);
      check(psdma_far_inst.ra_q[i], 32'h20);
      check(psdma_far_inst.ok_q[i], 32'h1);
    end
    pulse(7);
    wait_wr(16);
    bus(1'b0, psdma_pkg::OFS_DC1, 32'h0);
    check(rd_val, 32'hc2);
    check(dma_irq, 32'h0);
    // Forced word block with DMA ahead of a pending CPU interrupt
    bus(1'b1, psdma_pkg::OFS_DC1, 32'h0);
    bus(1'b1, psdma_pkg::OFS_CTRL, 32'h28);
    bus(1'b1, psdma_pkg::OFS_BLEN, 32'h04);
    bus(1'b1, psdma_pkg::OFS_SRC, 32'h60);
    bus(1'b1, psdma_pkg::OFS_DST, 32'h70);
    bus(1'b1, psdma_pkg::OFS_SYS, 32'h80);
    cpu_irq_pending <= 1'b1;
    bus(1'b1, psdma_pkg::OFS_DC1, 32'hc2);
    bus(1'b1, psdma_pkg::OFS_DC2, 32'h01);
    wait_wr(20);
    for (i = 16; i < 20; i++)
    begin
      check(psdma_far_inst.wa_q[i], 32'h70 + i - 16);
      check(psdma_far_inst.ra_q[i], 32'h60 + i % 2);
      check(psdma_far_inst.wd_q[i], (32'h60 + i % 2) ^ 32'h5a);
      check(psdma_far_inst.ok_q[i], 32'h1);
    end
    bus(1'b0, psdma_pkg::OFS_DC1, 32'h0);
    check(rd_val, 32'hc0);
    bus(1'b0, psdma_pkg::OFS_DC2, 32'h0);
    check(rd_val, 32'h01);
    bus(1'b0, psdma_pkg::OFS_SYS, 32'h0);
    check(rd_val, 32'h81);
    cpu_irq_pending <= 1'b0;
    print_verdict;
  end
endmodule
